// [src/wrtc_pkg.sv]
/*
 * constants for the wide real-time counter: widths, prescale ratios, reset values.
 * assumes a 20 MHz system clock and a 32.768 kHz crystal tick delivered as a level on a pin.
 */
package wrtc_pkg;
	// ************************************************************
	// widths and reset values
	// ************************************************************
	localparam int COUNT_W = 32;
	localparam logic [31:0] COUNT_RST = 32'h0000_0000;
	localparam logic [31:0] PERIOD_RST = 32'hFFFF_FFFF;
	localparam logic [31:0] COMPARE_RST = 32'hFFFF_FFFF;
	// ************************************************************
	// prescale ratios from the crystal rate
	// ************************************************************
	localparam int XTAL_HZ = 32768;
	localparam int FAST_REF_HZ = 1024;
	localparam int SLOW_REF_HZ = 1;
	localparam int DIV_FAST = XTAL_HZ / FAST_REF_HZ;
	localparam int DIV_SLOW = XTAL_HZ / SLOW_REF_HZ;
	localparam int DIV_W = 15;
	localparam logic [DIV_W-1:0] DIV_FAST_LAST = DIV_W'(DIV_FAST - 1);
	localparam logic [DIV_W-1:0] DIV_SLOW_LAST = DIV_W'(DIV_SLOW - 1);
	// ************************************************************
	// reference select
	// ************************************************************
	typedef enum logic {WRTC_REF_FAST = 1'b0, WRTC_REF_SLOW = 1'b1} wrtc_ref_e;
endpackage

// [src/wrtc_prescaler.sv]
/*
 * prescaler: turns synchronised crystal ticks into one-cycle reference ticks.
 * assumes xtalTick is already in the clk_sys domain and at most one cycle long.
 */
`timescale 1ns/10ps
module wrtc_prescaler
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic xtalTick,
	input wire logic useSlow,
	output logic refTick
);
	logic [wrtc_pkg::DIV_W-1:0] divCnt_q;
	logic [wrtc_pkg::DIV_W-1:0] divCnt_d;
	logic refTick_q;
	logic refTick_d;
	logic [wrtc_pkg::DIV_W-1:0] lastVal;

	// ************************************************************
	// divide by 32 or 32768 crystal ticks
	// ************************************************************
	// ratio pick
	always_comb
	begin
		lastVal = useSlow ? wrtc_pkg::DIV_SLOW_LAST : wrtc_pkg::DIV_FAST_LAST;
		divCnt_d = divCnt_q;
		refTick_d = 1'b0;
		if (xtalTick)
		begin
			// a ratio change with the count past the new last still wraps here
			if (divCnt_q >= lastVal)
			begin
				divCnt_d = '0;
				refTick_d = 1'b1;
			end
			else
				divCnt_d = divCnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			divCnt_q <= '0;
			refTick_q <= 1'b0;
		end
		else
		begin
			divCnt_q <= divCnt_d;
			refTick_q <= refTick_d;
		end
	end

	assign refTick = refTick_q;
endmodule

// [src/wrtc_counter.sv]
/*
 * wide real-time counter: 32-bit count of prescaled crystal ticks, compare and period match,
 * sticky status flags, optional interrupt requests and event pulses.
 * assumes crystal_osc_pin_a carries the oscillator output as a slow square wave; config inputs are static.
 */
`timescale 1ns/10ps
module wrtc_counter
#(
	parameter int COUNT_W = wrtc_pkg::COUNT_W
)
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic crystal_osc_pin_a,
	input wire logic onBattery,
	input wire logic refSelSlow,
	input wire logic [COUNT_W-1:0] compareVal,
	input wire logic [COUNT_W-1:0] periodVal,
	input wire logic cmpIrqEn,
	input wire logic ovfIrqEn,
	input wire logic cmpEvtEn,
	input wire logic ovfEvtEn,
	input wire logic cmpFlagClr,
	input wire logic ovfFlagClr,
	output logic [COUNT_W-1:0] countVal,
	output logic cmpFlag,
	output logic ovfFlag,
	output logic cmpIrq,
	output logic ovfIrq,
	output logic cmpEvt,
	output logic ovfEvt
);
	// ************************************************************
	// crystal pin synchroniser and edge detect
	// ************************************************************
	logic xtalMeta_q;
	logic xtalSync_q;
	logic xtalLast_q;
	logic battMeta_q;
	logic battSync_q;
	logic xtalTick;
	logic useSlow;
	logic refTick;

	// two flops per pin; the edge detector compares the second flop with a third flop on the crystal pin
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			xtalMeta_q <= 1'b0;
			xtalSync_q <= 1'b0;
			xtalLast_q <= 1'b0;
			battMeta_q <= 1'b0;
			battSync_q <= 1'b0;
		end
		else
		begin
			xtalMeta_q <= crystal_osc_pin_a;
			xtalSync_q <= xtalMeta_q;
			xtalLast_q <= xtalSync_q;
			battMeta_q <= onBattery;
			battSync_q <= battMeta_q;
		end
	end

	assign xtalTick = xtalSync_q & ~xtalLast_q;
	assign useSlow = refSelSlow | battSync_q;

	wrtc_prescaler i_wrtc_prescaler
	(
		.clk_sys(clk_sys),
		.rstn(rstn),
		.xtalTick(xtalTick),
		.useSlow(useSlow),
		.refTick(refTick)
	);

	// ************************************************************
	// counter, match detection, flags and outputs
	// ************************************************************
	logic [COUNT_W-1:0] count_q;
	logic [COUNT_W-1:0] count_d;
	logic cmpFlag_q;
	logic cmpFlag_d;
	logic ovfFlag_q;
	logic ovfFlag_d;
	logic cmpIrq_q;
	logic cmpIrq_d;
	logic ovfIrq_q;
	logic ovfIrq_d;
	logic cmpEvt_q;
	logic cmpEvt_d;
	logic ovfEvt_q;
	logic ovfEvt_d;
	logic cmpHit;
	logic ovfHit;

	// matches are judged on the value the count takes at this tick
	always_comb
	begin
		count_d = count_q;
		cmpHit = 1'b0;
		ovfHit = 1'b0;
		if (refTick)
		begin
			count_d = count_q + 1'b1;
			ovfHit = (count_d == periodVal);
			cmpHit = (count_d == compareVal);
			if (ovfHit)
			begin
				count_d = '0;
				// a zero compare meets the count as it wraps
				if (compareVal == '0)
					cmpHit = 1'b1;
			end
		end
		cmpFlag_d = cmpHit | (cmpFlag_q & ~cmpFlagClr);
		ovfFlag_d = ovfHit | (ovfFlag_q & ~ovfFlagClr);
		cmpIrq_d = cmpFlag_d & cmpIrqEn;
		ovfIrq_d = ovfFlag_d & ovfIrqEn;
		cmpEvt_d = cmpHit & cmpEvtEn;
		ovfEvt_d = ovfHit & ovfEvtEn;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			count_q <= COUNT_W'(wrtc_pkg::COUNT_RST);
			cmpFlag_q <= 1'b0;
			ovfFlag_q <= 1'b0;
			cmpIrq_q <= 1'b0;
			ovfIrq_q <= 1'b0;
			cmpEvt_q <= 1'b0;
			ovfEvt_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			cmpFlag_q <= cmpFlag_d;
			ovfFlag_q <= ovfFlag_d;
			cmpIrq_q <= cmpIrq_d;
			ovfIrq_q <= ovfIrq_d;
			cmpEvt_q <= cmpEvt_d;
			ovfEvt_q <= ovfEvt_d;
		end
	end

	assign countVal = count_q;
	assign cmpFlag = cmpFlag_q;
	assign ovfFlag = ovfFlag_q;
	assign cmpIrq = cmpIrq_q;
	assign ovfIrq = ovfIrq_q;
	assign cmpEvt = cmpEvt_q;
	assign ovfEvt = ovfEvt_q;

	// ************************************************************
	// assertions
	// ************************************************************
	// count moves only on a tick
	property p_countHold;
		@(posedge clk_sys) disable iff (!rstn)
		!refTick |=> $stable(count_q);
	endproperty
	a_countHold: assert property (p_countHold) else $error("count changed without a tick");

	// count steps by one when not wrapping
	property p_countStep;
		@(posedge clk_sys) disable iff (!rstn)
		refTick && (count_q + 1'b1 != periodVal) |=> count_q == $past(count_q) + 1'b1;
	endproperty
	a_countStep: assert property (p_countStep) else $error("count did not step by one");

	property p_wrap;
		@(posedge clk_sys) disable iff (!rstn)
		refTick && (count_q + 1'b1 == periodVal) |=> count_q == '0 && ovfFlag_q;
	endproperty
	a_wrap: assert property (p_wrap) else $error("period hit did not wrap and flag");

	property p_cmpSet;
		@(posedge clk_sys) disable iff (!rstn)
		refTick && (count_q + 1'b1 == compareVal) |=> cmpFlag_q;
	endproperty
	a_cmpSet: assert property (p_cmpSet) else $error("compare hit lost");

	property p_ovfEvt;
		@(posedge clk_sys) disable iff (!rstn)
		ovfEvt_q |-> $past(ovfEvtEn) && count_q == '0;
	endproperty
	a_ovfEvt: assert property (p_ovfEvt) else $error("overflow event without cause");

	property p_cmpIrq;
		@(posedge clk_sys) disable iff (!rstn)
		cmpIrq_q |-> cmpFlag_q && $past(cmpIrqEn);
	endproperty
	a_cmpIrq: assert property (p_cmpIrq) else $error("compare irq without flag or enable");

	property p_ovfSticky;
		@(posedge clk_sys) disable iff (!rstn)
		ovfFlag_q && !ovfFlagClr |=> ovfFlag_q;
	endproperty
	a_ovfSticky: assert property (p_ovfSticky) else $error("overflow flag dropped without clear");

	// crystal ticks per reference window; only the battery check reads these
	localparam logic [wrtc_pkg::DIV_W:0] SLOW_GAP = (wrtc_pkg::DIV_W+1)'(wrtc_pkg::DIV_SLOW);
	logic [wrtc_pkg::DIV_W:0] xtalGap_q;
	logic [wrtc_pkg::DIV_W:0] xtalGap_d;
	logic battWhole_q;
	logic battWhole_d;

	// a window is judged only if battery held from its start; a mid-window switch may wrap early
	always_comb
	begin
		if (refTick)
		begin
			xtalGap_d = {{wrtc_pkg::DIV_W{1'b0}}, xtalTick};
			battWhole_d = battSync_q;
		end
		else
		begin
			xtalGap_d = xtalGap_q + {{wrtc_pkg::DIV_W{1'b0}}, xtalTick};
			battWhole_d = battWhole_q & battSync_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			xtalGap_q <= '0;
			battWhole_q <= 1'b0;
		end
		else
		begin
			xtalGap_q <= xtalGap_d;
			battWhole_q <= battWhole_d;
		end
	end

	// on battery ticks are 32768 crystal edges apart
	property p_battSlow;
		@(posedge clk_sys) disable iff (!rstn)
		refTick && battWhole_q |-> xtalGap_q == SLOW_GAP;
	endproperty
	a_battSlow: assert property (p_battSlow) else $error("battery not forcing slow reference");

	c_wrap: cover property (@(posedge clk_sys) disable iff (!rstn) refTick && count_d == '0);
	c_cmp: cover property (@(posedge clk_sys) disable iff (!rstn) cmpHit);
	c_setClr: cover property (@(posedge clk_sys) disable iff (!rstn) cmpHit && cmpFlagClr);
endmodule

// [verification/wrtc_xtal_model.sv]
/*
 * crystal oscillator model: free-running square wave for the oscillator pin.
 * assumes the bench keeps the default half period of a few system clocks so runs stay short.
 */
`timescale 1ns/10ps
module wrtc_xtal_model
#(
	parameter int HALF_NS = 200
)
(
	output logic xtalOut
);
	// a crystal never stops, so the wave runs free; offset keeps edges off clk_sys edges
	initial
	begin
		xtalOut = 1'b0;
		#10;
		forever
			#(HALF_NS) xtalOut = ~xtalOut;
	end
endmodule

// [verification/test_wrtc_counter.sv]
/*
 * bench for the wide real-time counter: stepping, compare, period wrap, battery lock.
 * assumes a 400 ns crystal period, so one fast-reference count takes 256 system clocks.
 */
`timescale 1ns/10ps
module test_wrtc_counter;
	logic clk_sys, rstn, xtal, onBattery, refSlow, en, cmpFlagClr, ovfFlagClr;
	logic [31:0] compareVal, periodVal, countVal;
	logic cmpFlag, ovfFlag, cmpIrq, ovfIrq, cmpEvt, ovfEvt;
	int miscompares, n_checks, cmpN, ovfN, k;
	wrtc_xtal_model i_wrtc_xtal_model (.xtalOut(xtal));
	wrtc_counter i_wrtc_counter (.clk_sys(clk_sys), .rstn(rstn), .crystal_osc_pin_a(xtal),
		.onBattery(onBattery), .refSelSlow(refSlow), .compareVal(compareVal), .periodVal(periodVal),
		.cmpIrqEn(en), .ovfIrqEn(en), .cmpEvtEn(en), .ovfEvtEn(en), .cmpFlagClr(cmpFlagClr),
		.ovfFlagClr(ovfFlagClr), .countVal(countVal), .cmpFlag(cmpFlag), .ovfFlag(ovfFlag),
		.cmpIrq(cmpIrq), .ovfIrq(ovfIrq), .cmpEvt(cmpEvt), .ovfEvt(ovfEvt));
	// ************************************************************
	// clock, event tally, helpers
	// ************************************************************
	initial
	begin
		clk_sys = 1'b0;
		forever
			#25 clk_sys = ~clk_sys;
	end
	// pulses last one cycle, so count them at every edge
	always @(posedge clk_sys)
	begin
		if (cmpEvt === 1'b1)
			cmpN++;
		if (ovfEvt === 1'b1)
			ovfN++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bounded wait, so a stuck counter shows as a mismatch
	task automatic waitCount(input logic [31:0] v);
		for (k = 0; k < 20000 && countVal !== v; k++)
			@(negedge clk_sys);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_step();
		waitCount(32'h1);
		waitCount(32'h2);
		chk(32'(k), 32'h100);
	endtask
	task automatic t_cmp();
		waitCount(32'h3);
		// the tally sees a pulse one edge late; two edges also catch a pulse that stands too long
		repeat (2) @(negedge clk_sys);
		chk({cmpFlag, cmpIrq, 30'(cmpN)}, 32'hC000_0001);
		cmpFlagClr = 1'b1;
		@(negedge clk_sys);
		cmpFlagClr = 1'b0;
		chk({30'h0, cmpFlag, cmpIrq}, 32'h0);
	endtask
	task automatic t_wrap();
		waitCount(32'h5);
		waitCount(32'h0);
		chk(32'(k), 32'h100);
		repeat (2) @(negedge clk_sys);
		chk({ovfFlag, ovfIrq, 30'(ovfN)}, 32'hC000_0001);
		// clear held across the next hit: the hit must win
		en = 1'b0;
		cmpFlagClr = 1'b1;
		waitCount(32'h3);
		cmpFlagClr = 1'b0;
		@(negedge clk_sys);
		chk({cmpFlag, cmpIrq, ovfFlag, 29'(cmpN)}, 32'hA000_0001);
		ovfFlagClr = 1'b1;
		@(negedge clk_sys);
		ovfFlagClr = 1'b0;
		chk({31'h0, ovfFlag}, 32'h0);
	endtask
	task automatic t_batt();
		onBattery = 1'b1;
		repeat (2000) @(negedge clk_sys);
		chk(countVal, 32'h3);
		// battery off, slow kept by the select alone
		onBattery = 1'b0;
		refSlow = 1'b1;
		repeat (2000) @(negedge clk_sys);
		chk(countVal, 32'h3);
		// back to fast: divider is past its last, wraps at once, then 32 ticks a count
		refSlow = 1'b0;
		waitCount(32'h4);
		waitCount(32'h5);
		chk(32'(k), 32'h100);
	endtask
	// inputs change at the falling edge; fast reference except in the battery scenario
	initial
	begin
		{rstn, onBattery, refSlow, cmpFlagClr, ovfFlagClr} = 5'h0;
		en = 1'b1;
		compareVal = 32'h3;
		periodVal = 32'h6;
		repeat (20) @(negedge clk_sys);
		rstn = 1'b1;
		t_step();
		t_cmp();
		t_wrap();
		t_batt();
		end_of_test();
	end
	// watchdog well beyond the roughly 6600 cycles the scenarios need
	initial
	begin
		repeat (40000) @(posedge clk_sys);
		miscompares++;
		end_of_test();
	end
endmodule
